// File: logic/urc_pkg.sv
// shared constants, state codes and helpers of the serial controller
package urc_pkg;

	// ----------------------------------------------------------------
	// queue depth, timing and line level
	// ----------------------------------------------------------------
	localparam int unsigned FIFO_DEPTH   = 16;      // entries per direction
	localparam logic [3:0]  OVS_MID      = 4'h7;    // start bit checked mid-bit
	localparam logic [3:0]  OVS_LAST     = 4'hf;    // 16 ticks per bit
	localparam logic [5:0]  BIT_LAST     = 6'h0f;   // last tick of a tx bit
	localparam logic [5:0]  STOP_1_LAST  = 6'h0f;   // one stop bit
	localparam logic [5:0]  STOP_15_LAST = 6'h17;   // one and a half stop bits
	localparam logic [5:0]  STOP_2_LAST  = 6'h1f;   // two stop bits
	localparam logic [5:0]  IR_PULSE     = 6'h03;   // 3 of 16 ticks lit
	localparam logic [16:0] BRD_OFFSET   = 17'h2;   // divider offset, normal mode
	localparam logic        LINE_IDLE    = 1'b1;    // reset level of lines

	// ----------------------------------------------------------------
	// function select codes and field positions
	// ----------------------------------------------------------------
	localparam logic [1:0] FUN_UART  = 2'h0;
	localparam logic [1:0] FUN_IRDA  = 2'h2;
	localparam logic [1:0] FUN_RS485 = 2'h3;
	localparam int unsigned IRQ_RX_THRESHOLD = 0;
	localparam int unsigned IRQ_TX_EMPTY     = 1;
	localparam int unsigned IRQ_LINE_ERROR   = 2;
	localparam int unsigned IRQ_MODEM        = 3;
	localparam int unsigned IRQ_RX_TIMEOUT   = 4;
	localparam int unsigned IRQ_BUF_ERROR    = 5;
	localparam int unsigned ERR_PARITY       = 8;   // rx entry bit positions
	localparam int unsigned ERR_FRAME        = 9;
	localparam int unsigned ERR_BREAK        = 10;

	// ----------------------------------------------------------------
	// state codes
	// ----------------------------------------------------------------
	typedef enum logic [5:0] {
		TX_IDLE = 6'h01, TX_START = 6'h02, TX_DATA = 6'h04,
		TX_PAR = 6'h08, TX_STOP = 6'h10, TX_GAP = 6'h20
	} urc_tx_st_t;
	typedef enum logic [5:0] {
		RX_IDLE = 6'h01, RX_START = 6'h02, RX_DATA = 6'h04,
		RX_PAR = 6'h08, RX_STOP = 6'h10, RX_WAIT = 6'h20
	} urc_rx_st_t;

	// fill level in bytes of a trigger code
	function automatic logic [4:0] trig_bytes(input logic [3:0] code);
		case (code)
			4'h0:    trig_bytes = 5'h01;
			4'h1:    trig_bytes = 5'h04;
			4'h2:    trig_bytes = 5'h08;
			default: trig_bytes = 5'h0e;
		endcase
	endfunction

	// parity bit for the low data bits of a character
	function automatic logic par_bit(input logic [7:0] d, input logic [1:0] len,
		input logic even, input logic stick);
		logic [7:0] m;
		m = d & (8'hff >> (2'h3 - len));
		if (stick)
			par_bit = ~even;
		else
			par_bit = even ? ^m : ~^m;
	endfunction

endpackage

// File: logic/urc_fifo.sv
// synchronous first-in first-out store used for both directions
`timescale 1ns/1ps
`default_nettype none
module urc_fifo #(
	parameter int unsigned W     = 11,
	parameter int unsigned DEPTH = 16,
	parameter int unsigned AW    = $clog2(DEPTH)
) (
	input  wire logic          ref_clk_i,
	input  wire logic          sys_rst_i,
	input  wire logic          push_i,
	input  wire logic [W-1:0]  data_i,
	input  wire logic          pop_i,
	output logic      [W-1:0]  data_o,
	output logic      [AW:0]   count_o,
	output logic               full_o,
	output logic               empty_o
);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
	} urc_fifo_st_t;

	urc_fifo_st_t s_r;
	urc_fifo_st_t s_nxt;
	logic         pw;
	logic         pp;

	// ----------------------------------------------------------------
	// status and head word
	// ----------------------------------------------------------------
	assign full_o  = (s_r.cnt == (AW+1)'(DEPTH));
	assign empty_o = (s_r.cnt == '0);
	assign count_o = s_r.cnt;
	assign data_o  = s_r.mem[s_r.rp];
	assign pw      = push_i && !full_o;
	assign pp      = pop_i && !empty_o;

	// pointer and fill update, refused pushes are dropped
	always_comb begin
		s_nxt = s_r;
		if (pw) begin
			s_nxt.mem[s_r.wp] = data_i;
			s_nxt.wp = s_r.wp + 1'b1;
		end
		if (pp)
			s_nxt.rp = s_r.rp + 1'b1;
		s_nxt.cnt = s_r.cnt + (AW+1)'(pw) - (AW+1)'(pp);
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
endmodule // urc_fifo
`default_nettype wire

// File: logic/urc_top.sv
// serial controller core with infrared and multidrop functions
//
// Contract
// - separate 16-entry transmit and receive queues, both directions concurrent
// - each received entry carries parity, framing and break flags
// - character length five to eight bits both directions
// - parity even, odd, none or stick
// - one, one and a half or two stop bits sent
// - flag break, framing, parity, receive and transmit overflow
// - receive time-out after programmable 8-bit count of idle bit times
// - programmable idle gap between stop bit and next start bit
// - six individually enabled interrupt sources
// - data-available raised when receive fill reaches programmed level
// - infrared bit rate is clock over sixteen times divider
// - infrared encoder pulses for zero bits, dark for ones
// - infrared pulse lasts three sixteenths of a bit
// - infrared receive inversion defaults to one, input idles high
// - infrared decoder sees start on low input, rebuilds NRZ stream
// - multidrop ninth bit one marks address, zero marks data
// - stick parity sends ninth bit as inverse of even select
// - receiver disabled drops characters until address byte, then stores it
// - address byte interrupts and clears receiver disable itself
// - auto address keeps bytes from matching address until other address
// - request-to-send drives driver enable, polarity set by invert control
// - auto flow drops request-to-send when receive fill hits trigger
// - auto flow starts a character only while clear-to-send asserted
// - trigger code 0,1,2 gives 1,4,8 bytes, others 14
`timescale 1ns/1ps
`default_nettype none
module urc_top #(
	parameter int unsigned FIFO_DEPTH = urc_pkg::FIFO_DEPTH,
	parameter int unsigned CW         = $clog2(FIFO_DEPTH) + 1
) (
	input  wire logic          ref_clk_i,
	input  wire logic          sys_rst_i,
	input  wire logic [7:0]    tx_data_i,
	input  wire logic          tx_valid_i,
	output logic               tx_ready_o,
	output logic      [7:0]    rx_data_o,
	output logic      [2:0]    rx_err_o,
	output logic               rx_valid_o,
	input  wire logic          rx_ready_i,
	input  wire logic [1:0]    data_len_i,
	input  wire logic          stop_two_i,
	input  wire logic          parity_enable_i,
	input  wire logic          even_parity_select_i,
	input  wire logic          stick_parity_enable_i,
	input  wire logic [15:0]   baud_divisor_i,
	input  wire logic [1:0]    function_select_i,
	input  wire logic          timeout_en_i,
	input  wire logic [7:0]    timeout_count_i,
	input  wire logic [7:0]    tx_gap_delay_i,
	input  wire logic [3:0]    rx_trig_lvl_i,
	input  wire logic [3:0]    rts_trigger_level_i,
	input  wire logic          auto_rts_en_i,
	input  wire logic          auto_cts_en_i,
	input  wire logic          rts_sw_i,
	input  wire logic          rts_level_invert_i,
	input  wire logic          irda_tx_inv_i,
	input  wire logic          irda_rx_inv_i,
	input  wire logic          multidrop_mode_enable_i,
	input  wire logic          auto_address_match_i,
	input  wire logic          auto_direction_i,
	input  wire logic [7:0]    addr_match_i,
	input  wire logic          receiver_disable_set_i,
	input  wire logic          receiver_disable_clr_i,
	input  wire logic [5:0]    irq_en_i,
	input  wire logic [5:0]    irq_clr_i,
	output logic               receiver_disable_o,
	output logic               tx_empty_o,
	output logic      [CW-1:0] tx_count_o,
	output logic      [CW-1:0] rx_count_o,
	output logic               tx_overflow_o,
	output logic               rx_overflow_o,
	output logic      [5:0]    irq_src_o,
	output logic               irq_o,
	input  wire logic          rx_pin_i,
	input  wire logic          cts_n_i,
	output logic               tx_pin_o,
	output logic               rts_o
);
	typedef struct packed {
		urc_pkg::urc_tx_st_t tst;
		logic [5:0]          ttk;
		logic [2:0]          tbit;
		logic [7:0]          tsh;
		logic [7:0]          tgap;
		logic                tpin;
		logic                rts;
		urc_pkg::urc_rx_st_t rst;
		logic [3:0]          rtk;
		logic [2:0]          rbit;
		logic [7:0]          rsh;
		logic                rpar;
		logic [2:0]          rxs;
		logic [2:0]          ctss;
		logic                rxf;
		logic                ctsf;
		logic [16:0]         bdiv;
		logic [3:0]          irc;
		logic                irnrz;
		logic [3:0]          tosub;
		logic [7:0]          tocnt;
		logic                tout;
		logic                rxdis;
		logic                matched;
		logic                rls;
		logic                mdm;
		logic                txovf;
		logic                rxovf;
	} urc_st_t;

	urc_st_t          s_r;
	urc_st_t          s_nxt;
	logic             irda;
	logic             rs485;
	logic [16:0]      lim;
	logic             tick;
	logic             rin;
	logic [2:0]       dlast;
	logic [5:0]       slast;
	logic             tx_pop;
	logic             tx_full;
	logic [10:0]      tx_word;
	logic             rx_push;
	logic             rx_pop;
	logic             rx_full;
	logic             rx_empty;
	logic [10:0]      rx_word;
	logic [10:0]      rx_head;
	logic             nrz;
	logic             de;

	// ----------------------------------------------------------------
	// queues
	// ----------------------------------------------------------------
	urc_fifo #(.W(11), .DEPTH(FIFO_DEPTH)) u_txq (
		.ref_clk_i (ref_clk_i), .sys_rst_i (sys_rst_i),
		.push_i (tx_valid_i), .data_i ({3'h0, tx_data_i}), .pop_i (tx_pop),
		.data_o (tx_word), .count_o (tx_count_o), .full_o (tx_full), .empty_o (tx_empty_o)
	);
	urc_fifo #(.W(11), .DEPTH(FIFO_DEPTH)) u_rxq (
		.ref_clk_i (ref_clk_i), .sys_rst_i (sys_rst_i),
		.push_i (rx_push), .data_i (rx_word), .pop_i (rx_pop),
		.data_o (rx_head), .count_o (rx_count_o), .full_o (rx_full), .empty_o (rx_empty)
	);

	// ----------------------------------------------------------------
	// host side status
	// ----------------------------------------------------------------
	assign tx_ready_o         = !tx_full;
	assign rx_valid_o         = !rx_empty;
	assign rx_pop             = rx_ready_i && !rx_empty;
	assign rx_data_o          = rx_head[7:0];
	assign rx_err_o           = rx_head[10:8];
	assign receiver_disable_o = s_r.rxdis;
	assign tx_overflow_o      = s_r.txovf;
	assign rx_overflow_o      = s_r.rxovf;
	assign tx_pin_o           = s_r.tpin;
	assign rts_o              = s_r.rts;
	assign irq_src_o[urc_pkg::IRQ_RX_THRESHOLD] =
		rx_count_o >= CW'(urc_pkg::trig_bytes(rx_trig_lvl_i));
	assign irq_src_o[urc_pkg::IRQ_TX_EMPTY]   = tx_empty_o;
	assign irq_src_o[urc_pkg::IRQ_LINE_ERROR] = s_r.rls;
	assign irq_src_o[urc_pkg::IRQ_MODEM]      = s_r.mdm;
	assign irq_src_o[urc_pkg::IRQ_RX_TIMEOUT] = s_r.tout;
	assign irq_src_o[urc_pkg::IRQ_BUF_ERROR]  = s_r.txovf | s_r.rxovf;
	assign irq_o = |(irq_src_o & irq_en_i);

	// ----------------------------------------------------------------
	// mode decode and baud tick, 16 ticks per bit
	// ----------------------------------------------------------------
	assign irda  = (function_select_i == urc_pkg::FUN_IRDA);
	assign rs485 = (function_select_i == urc_pkg::FUN_RS485);
	always_comb begin
		// infrared drops the offset; a zero infrared divisor is run as one
		if (irda)
			lim = {1'b0, baud_divisor_i};
		else
			lim = {1'b0, baud_divisor_i} + urc_pkg::BRD_OFFSET;
		if (lim == '0)
			lim = 17'h1;
	end
	assign tick  = (s_r.bdiv >= lim - 17'h1);
	assign rin   = irda ? s_r.irnrz : s_r.rxf;
	assign dlast = 3'h4 + {1'b0, data_len_i};
	assign slast = !stop_two_i ? urc_pkg::STOP_1_LAST :
		(data_len_i == 2'h0) ? urc_pkg::STOP_15_LAST : urc_pkg::STOP_2_LAST;

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic pe;
		logic fe;
		logic bi;
		logic store;
		logic addr;
		logic lit;
		pe = 1'b0;
		fe = 1'b0;
		bi = 1'b0;
		store = 1'b0;
		addr = 1'b0;
		lit = 1'b0;
		s_nxt = s_r;
		tx_pop = 1'b0;
		rx_push = 1'b0;
		rx_word = '0;
		// pin synchronisers, a level counts once stages two and three agree
		s_nxt.rxs = {s_r.rxs[1:0], rx_pin_i};
		s_nxt.ctss = {s_r.ctss[1:0], cts_n_i};
		if (s_r.rxs[1] == s_r.rxs[2])
			s_nxt.rxf = s_r.rxs[2];
		if (s_r.ctss[1] == s_r.ctss[2])
			s_nxt.ctsf = s_r.ctss[2];
		// sticky flags: a set in the cycle of a clear wins
		s_nxt.mdm = (s_nxt.ctsf != s_r.ctsf) | (s_r.mdm & ~irq_clr_i[urc_pkg::IRQ_MODEM]);
		s_nxt.rls = s_r.rls & ~irq_clr_i[urc_pkg::IRQ_LINE_ERROR];
		s_nxt.txovf = (tx_valid_i & tx_full) |
			(s_r.txovf & ~irq_clr_i[urc_pkg::IRQ_BUF_ERROR]);
		s_nxt.rxovf = s_r.rxovf & ~irq_clr_i[urc_pkg::IRQ_BUF_ERROR];
		s_nxt.rxdis = receiver_disable_set_i | (s_r.rxdis & ~receiver_disable_clr_i);
		s_nxt.bdiv = tick ? '0 : s_r.bdiv + 17'h1;
		if (tick) begin
			// infrared decoder: a pulse stretches to one low bit time
			lit = irda_rx_inv_i ? ~s_r.rxf : s_r.rxf;
			if (lit) begin
				s_nxt.irc = urc_pkg::OVS_LAST;
				s_nxt.irnrz = 1'b0;
			end else begin
				if (s_r.irc != 4'h0)
					s_nxt.irc = s_r.irc - 4'h1;
				else
					s_nxt.irnrz = 1'b1;
			end
			// receiver
			s_nxt.rtk = s_r.rtk + 4'h1;
			case (s_r.rst)
				urc_pkg::RX_IDLE: begin
					s_nxt.rtk = 4'h0;
					if (!rin)
						s_nxt.rst = urc_pkg::RX_START;
				end
				urc_pkg::RX_START: begin
					if (s_r.rtk == urc_pkg::OVS_MID) begin
						s_nxt.rtk = 4'h0;
						s_nxt.rbit = 3'h0;
						s_nxt.rsh = 8'h00;
						s_nxt.rst = rin ? urc_pkg::RX_IDLE : urc_pkg::RX_DATA;
					end
				end
				urc_pkg::RX_DATA: begin
					if (s_r.rtk == urc_pkg::OVS_LAST) begin
						s_nxt.rsh[s_r.rbit] = rin;
						s_nxt.rbit = s_r.rbit + 3'h1;
						if (s_r.rbit == dlast)
							s_nxt.rst = parity_enable_i ? urc_pkg::RX_PAR : urc_pkg::RX_STOP;
					end
				end
				urc_pkg::RX_PAR: begin
					if (s_r.rtk == urc_pkg::OVS_LAST) begin
						s_nxt.rpar = rin;
						s_nxt.rst = urc_pkg::RX_STOP;
					end
				end
				urc_pkg::RX_STOP: begin
					if (s_r.rtk == urc_pkg::OVS_LAST) begin
						s_nxt.rst = rin ? urc_pkg::RX_IDLE : urc_pkg::RX_WAIT;
						fe = !rin;
						bi = !rin && (s_r.rsh == 8'h00) && !(parity_enable_i && s_r.rpar);
						pe = parity_enable_i && !rs485 && (s_r.rpar != urc_pkg::par_bit(s_r.rsh,
							data_len_i, even_parity_select_i, stick_parity_enable_i));
						addr = rs485 && parity_enable_i && s_r.rpar;
						if (rs485 && auto_address_match_i) begin
							if (addr)
								s_nxt.matched = (s_r.rsh == addr_match_i);
							store = addr ? (s_r.rsh == addr_match_i) : s_r.matched;
						end else if (rs485 && multidrop_mode_enable_i && addr) begin
							store = 1'b1;
							s_nxt.rxdis = 1'b0;
							s_nxt.rls = 1'b1;
						end else begin
							store = !s_r.rxdis;
						end
						if (store) begin
							rx_word = {bi, fe, pe, s_r.rsh};
							rx_push = 1'b1;
							s_nxt.rls = s_nxt.rls | pe | fe | bi;
							s_nxt.rxovf = s_nxt.rxovf | rx_full;
						end
					end
				end
				urc_pkg::RX_WAIT: begin
					if (rin)
						s_nxt.rst = urc_pkg::RX_IDLE;
				end
				default: s_nxt.rst = urc_pkg::RX_IDLE;
			endcase
			// transmitter
			s_nxt.ttk = s_r.ttk + 6'h1;
			case (s_r.tst)
				urc_pkg::TX_IDLE: begin
					s_nxt.ttk = 6'h0;
					if (!tx_empty_o && !(auto_cts_en_i && s_r.ctsf)) begin
						tx_pop = 1'b1;
						s_nxt.tsh = tx_word[7:0];
						s_nxt.tbit = 3'h0;
						s_nxt.tst = urc_pkg::TX_START;
					end
				end
				urc_pkg::TX_START: begin
					if (s_r.ttk == urc_pkg::BIT_LAST) begin
						s_nxt.ttk = 6'h0;
						s_nxt.tst = urc_pkg::TX_DATA;
					end
				end
				urc_pkg::TX_DATA: begin
					if (s_r.ttk == urc_pkg::BIT_LAST) begin
						s_nxt.ttk = 6'h0;
						s_nxt.tbit = s_r.tbit + 3'h1;
						if (s_r.tbit == dlast)
							s_nxt.tst = parity_enable_i ? urc_pkg::TX_PAR : urc_pkg::TX_STOP;
					end
				end
				urc_pkg::TX_PAR: begin
					if (s_r.ttk == urc_pkg::BIT_LAST) begin
						s_nxt.ttk = 6'h0;
						s_nxt.tst = urc_pkg::TX_STOP;
					end
				end
				urc_pkg::TX_STOP: begin
					if (s_r.ttk == slast) begin
						s_nxt.ttk = 6'h0;
						s_nxt.tgap = 8'h00;
						s_nxt.tst = (tx_gap_delay_i != 8'h00) ? urc_pkg::TX_GAP : urc_pkg::TX_IDLE;
					end
				end
				urc_pkg::TX_GAP: begin
					if (s_r.ttk == urc_pkg::BIT_LAST) begin
						s_nxt.ttk = 6'h0;
						s_nxt.tgap = s_r.tgap + 8'h01;
						if (s_r.tgap + 8'h01 >= tx_gap_delay_i)
							s_nxt.tst = urc_pkg::TX_IDLE;
					end
				end
				default: s_nxt.tst = urc_pkg::TX_IDLE;
			endcase
		end
		// receive time-out counts idle bit times while data waits
		if (!timeout_en_i || rx_empty || rx_push || rx_pop) begin
			s_nxt.tosub = 4'h0;
			s_nxt.tocnt = 8'h00;
			s_nxt.tout = 1'b0;
		end else if (tick) begin
			s_nxt.tosub = s_r.tosub + 4'h1;
			if (s_r.tosub == urc_pkg::OVS_LAST) begin
				if (s_r.tocnt >= timeout_count_i)
					s_nxt.tout = 1'b1;
				else
					s_nxt.tocnt = s_r.tocnt + 8'h01;
			end
		end
		// serial line level of the next state
		case (s_nxt.tst)
			urc_pkg::TX_START: nrz = 1'b0;
			urc_pkg::TX_DATA:  nrz = s_nxt.tsh[s_nxt.tbit];
			urc_pkg::TX_PAR:   nrz = urc_pkg::par_bit(s_nxt.tsh, data_len_i,
				even_parity_select_i, stick_parity_enable_i);
			default:           nrz = 1'b1;
		endcase
		if (irda)
			s_nxt.tpin = (!nrz && s_nxt.ttk < urc_pkg::IR_PULSE) ^ irda_tx_inv_i;
		else
			s_nxt.tpin = nrz;
		// driver enable covers pending data, the character and its gap
		de = (s_nxt.tst != urc_pkg::TX_IDLE) || !tx_empty_o;
		if (rs485 && auto_direction_i)
			s_nxt.rts = de ^ rts_level_invert_i;
		else if (auto_rts_en_i)
			s_nxt.rts = (rx_count_o < CW'(urc_pkg::trig_bytes(rts_trigger_level_i)))
				^ rts_level_invert_i;
		else
			s_nxt.rts = rts_sw_i ^ rts_level_invert_i;
	end

	// state register
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_r <= '0;
			s_r.tst <= urc_pkg::TX_IDLE;
			s_r.rst <= urc_pkg::RX_IDLE;
			s_r.rxs <= {3{urc_pkg::LINE_IDLE}};
			s_r.ctss <= {3{urc_pkg::LINE_IDLE}};
			s_r.rxf <= urc_pkg::LINE_IDLE;
			s_r.ctsf <= urc_pkg::LINE_IDLE;
			s_r.irnrz <= urc_pkg::LINE_IDLE;
			s_r.tpin <= urc_pkg::LINE_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	a_rx_fill_bound: assert property (rx_count_o <= CW'(FIFO_DEPTH))
		else $error("rx fill above depth");
	a_err_travel: assert property (rx_valid_o && !rx_ready_i |=> $stable(rx_err_o))
		else $error("rx flags changed under held entry");
	a_stop_high: assert property (!irda && s_r.tst == urc_pkg::TX_STOP |-> s_r.tpin)
		else $error("stop bit not high");
	a_stick_ninth: assert property (!irda && parity_enable_i && stick_parity_enable_i
		&& s_r.tst == urc_pkg::TX_PAR |-> s_r.tpin == !even_parity_select_i)
		else $error("stick ninth bit wrong");
	a_cts_hold: assert property (s_r.tst == urc_pkg::TX_IDLE && auto_cts_en_i && s_r.ctsf
		|=> s_r.tst == urc_pkg::TX_IDLE)
		else $error("sent without clear-to-send");
	a_ir_dark: assert property (irda && s_r.tst != urc_pkg::TX_IDLE
		&& s_r.ttk >= urc_pkg::IR_PULSE |-> s_r.tpin == irda_tx_inv_i)
		else $error("ir pulse too long");
	a_dir_enable: assert property (rs485 && auto_direction_i && s_r.tst != urc_pkg::TX_IDLE
		|-> s_r.rts == !rts_level_invert_i)
		else $error("driver off during character");
	a_rx_overflow: assert property (rx_push && rx_full |=> s_r.rxovf)
		else $error("rx overflow not flagged");
	a_tout_data: assert property (s_r.tout |-> !$past(rx_empty) && $past(timeout_en_i))
		else $error("time-out without waiting data");
	a_tx_start_low: assert property (!irda && $rose(s_r.tst == urc_pkg::TX_START)
		|-> !s_r.tpin && s_r.ttk == 6'h00)
		else $error("start bit shape wrong");

	c_tx_char: cover property (s_r.tst == urc_pkg::TX_STOP ##1 s_r.tst == urc_pkg::TX_GAP);
	c_rx_store: cover property (rx_push && rx_word[urc_pkg::ERR_PARITY] == 1'b0);
	c_ir_pulse: cover property (irda && s_r.tst == urc_pkg::TX_DATA && s_r.tpin != irda_tx_inv_i);
	c_addr_hit: cover property (rs485 && auto_address_match_i && $rose(s_r.matched));
endmodule // urc_top
`default_nettype wire

// File: verification/urc_peer.sv
// remote serial device model that faces the line pins of the controller
`timescale 1ns/1ps
`default_nettype none
module urc_peer #(
	parameter int BIT = 32
) (
	input  wire logic clk_i,
	input  wire logic line_i,
	output logic      line_o
);
	logic [8:0] got;  // nine bit times seen after the last start bit
	initial line_o = 1'b1;
	// send start, n bits lsb first, a stop level, then idle high
	task automatic send(input logic [8:0] v, input int n, input logic stp);
		line_o = 1'b0;
		repeat (BIT) @(negedge clk_i);
		for (int i = 0; i < n; i++) begin
			line_o = v[i];  // ninth bit marks an address
			repeat (BIT) @(negedge clk_i);
		end
		line_o = stp;
		repeat (BIT) @(negedge clk_i);
		line_o = 1'b1;
		repeat (2 * BIT) @(negedge clk_i);
	endtask
	// sample the transmit line mid-bit after each start edge
	always begin
		@(negedge line_i);
		repeat (BIT / 2) @(negedge clk_i);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT) @(negedge clk_i);
			got[i] = line_i;
		end
	end
endmodule // urc_peer
`default_nettype wire

// File: verification/test_uart_irda_rs485_controller.sv
// self-checking bench of the serial controller core
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module test_uart_irda_rs485_controller;
	localparam int BIT = 32;  // clocks per bit at divisor 0
	logic       clk = 0, rst = 1, txv = 0, rxr = 0, pe = 0, ev = 0, sp = 0, md = 0, aad = 0, auto_direction = 0, dset = 0;
	logic       ctsn = 0, acts = 0, arts = 0, tmo = 0, inv = 0, st2 = 0, rsw = 0, dclr = 0;
	logic       txr, rxv, rdis, txe, txo, rxo, irq, txp, rxp, rts;
	logic [1:0] len = 2'h3, fsel = 2'h0;
	logic [2:0] rxe, cfg [5] = '{3'b000, 3'b110, 3'b100, 3'b111, 3'b101};
	logic [3:0] rtl = 4'h2;
	logic [4:0] txc, rxc;
	logic [5:0] isrc, ien = 6'h30, clr = 6'h00;
	logic [7:0] txd = 8'h00, rxd, gap = 8'h00, d;
	logic [15:0] baud_divisor = 16'h0000;
	logic [8:0] hi = 9'h000;
	logic [8:0] m, seq [6] = '{9'h133, 9'h055, 9'h142, 9'h066, 9'h133, 9'h077};
	int         n_errors = 0, compares = 0, t0 = -1, t1 = 0;
	urc_top dut (.ref_clk_i(clk), .sys_rst_i(rst), .tx_data_i(txd), .tx_valid_i(txv), .tx_ready_o(txr),
		.rx_data_o(rxd), .rx_err_o(rxe), .rx_valid_o(rxv), .rx_ready_i(rxr), .data_len_i(len), .stop_two_i(st2),
		.parity_enable_i(pe), .even_parity_select_i(ev), .stick_parity_enable_i(sp), .baud_divisor_i(baud_divisor),
		.function_select_i(fsel), .timeout_en_i(tmo), .timeout_count_i(8'h00), .tx_gap_delay_i(gap),
		.rx_trig_lvl_i(rtl), .rts_trigger_level_i(4'h1), .auto_rts_en_i(arts), .auto_cts_en_i(acts), .rts_sw_i(rsw),
		.rts_level_invert_i(inv), .irda_tx_inv_i(1'b0), .irda_rx_inv_i(1'b1), .multidrop_mode_enable_i(md),
		.auto_address_match_i(aad), .auto_direction_i(auto_direction), .addr_match_i(8'h42), .receiver_disable_set_i(dset),
		.receiver_disable_clr_i(dclr), .irq_en_i(ien), .irq_clr_i(clr), .receiver_disable_o(rdis), .tx_empty_o(txe),
		.tx_count_o(txc), .rx_count_o(rxc), .tx_overflow_o(txo), .rx_overflow_o(rxo), .irq_src_o(isrc), .irq_o(irq),
		.rx_pin_i(rxp), .cts_n_i(ctsn), .tx_pin_o(txp), .rts_o(rts));
	urc_peer #(.BIT(BIT)) p (.clk_i(clk), .line_i(txp), .line_o(rxp));
	initial begin
		forever #10 clk = ~clk;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	// offer one byte to the transmit queue
	task automatic put(input logic [7:0] v);
		txd = v;
		txv = 1'b1;
		wt(1);
		txv = 0;
		wt(1);
	endtask
	// compare the receive head under a flag mask, then pop it
	task automatic pop(input logic [7:0] v, input logic [2:0] e, input logic [2:0] mk);
		`CHK({rxv, rxd, rxe & mk}, {1'b1, v, e})
		rxr = 1'b1;
		wt(1);
		rxr = 0;
		wt(1);
	endtask
	task automatic wrap_up;
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// watchdog well beyond the expected run length
	initial begin
		repeat (80000) @(posedge clk);
		n_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		wrap_up();
	end
	initial begin
		wt(4);
		rst = 0;
		wt(1);
		`CHK({txp, rxv, txr, rts}, 4'b1010)
		for (int l = 0; l < 4; l++) begin
			len = l[1:0];
			st2 = (l == 0);
			put(8'h96);
			wt(13 * BIT);
			m = 9'h1ff << (l + 5);
			`CHK(p.got, m | ({1'b0, 8'h96} & ~m))
		end
		for (int k = 0; k < 5; k++) begin
			{pe, ev, sp} = cfg[k];
			d = 8'h5b ^ k[7:0];
			put(d);
			wt(13 * BIT);
			`CHK(p.got, {!pe ? 1'b1 : sp ? !ev : ev ? ^d : ~^d, d})
		end
		{pe, ev, sp, acts, ctsn} = 5'b00011;
		wt(8);
		for (int i = 0; i < 17; i++)
			put(i[7:0]);
		`CHK({txc, txr, txo, isrc[5]}, 8'b10000011)
		wt(3 * BIT);
		`CHK(txp, 1'b1)
		ctsn = 0;
		wt(16 * 11 * BIT);
		`CHK({txe, p.got}, {1'b1, 9'h10f})
		clr = 6'h20;
		wt(1);
		clr = 0;
		wt(1);
		`CHK({txo, isrc[5]}, 2'b00)
		$display("tx tests done");
		p.send(9'h0a5, 8, 1'b1);
		pop(8'ha5, 3'h0, 3'h7);
		p.send(9'h03c, 8, 1'b0);
		pop(8'h3c, 3'h2, 3'h3);
		p.send(9'h000, 8, 1'b0);
		pop(8'h00, 3'h4, 3'h5);
		{arts, tmo} = 2'b11;
		for (int i = 0; i < 17; i++) begin
			p.send({1'b0, i[7:0]}, 8, 1'b1);
			`CHK({rxc, isrc[0]}, {5'(i < 16 ? i + 1 : 16), i > 6})
			if (i < 4)
				`CHK(rts, i < 3)
		end
		`CHK({rxo, isrc[4], isrc[5], irq}, 4'hf)
		ien = 0;
		wt(1);
		`CHK(irq, 1'b0)
		for (int i = 0; i < 16; i++)
			pop(i[7:0], 3'h0, 3'h7);
		`CHK({rxv, rxc}, 6'h00)
		{arts, tmo, pe, ev} = 4'b0011;
		p.send(9'h10f, 9, 1'b1);
		pop(8'h0f, 3'h1, 3'h7);
		$display("rx tests done");
		{fsel, md, dclr, clr} = {4'hf, 6'h04};
		wt(1);
		{dclr, dset, clr} = {2'b01, 6'h00};
		wt(1);
		dset = 0;
		p.send(9'h011, 9, 1'b1);
		`CHK({rdis, rxc, isrc[2]}, 7'h40)
		p.send(9'h1a7, 9, 1'b1);
		`CHK({rdis, rxc, isrc[2]}, 7'h03)
		pop(8'ha7, 3'h0, 3'h7);
		{md, aad} = 2'b01;
		foreach (seq[j])
			p.send(seq[j], 9, 1'b1);
		`CHK(rxc, 5'h02)
		pop(8'h42, 3'h0, 3'h7);
		pop(8'h66, 3'h0, 3'h7);
		{aad, auto_direction, gap} = {2'b01, 8'h02};
		put(8'h81);
		wt(2);
		`CHK(rts, 1'b1)
		wt(11 * BIT);
		`CHK(rts, 1'b1)
		wt(2 * BIT);
		`CHK({rts, p.got}, {1'b0, 9'h081})
		inv = 1'b1;
		wt(2);
		`CHK(rts, 1'b1)
		$display("multidrop tests done");
		{fsel, auto_direction, pe, baud_divisor} = {2'h2, 2'b00, 16'h0002}; // plain divider only in infrared
		wt(BIT);
		put(8'hf0);
		for (int c = 0; c < 400; c++) begin
			hi = hi + {8'h00, txp};
			if (txp === 1'b1) begin
				t0 = (t0 < 0) ? c : t0;
				t1 = c;
			end
			wt(1);
		end
		`CHK(hi, 9'h01e)
		`CHK(t1 - t0, 32'h85)
		$display("infrared tests done");
		wrap_up();
	end
endmodule // test_uart_irda_rs485_controller
`default_nettype wire
